/* cbc_pkg.sv */
// constants for the board processor io and branch control block
//----------------------------------------------------------------
// Function
//----------------------------------------------------------------
// Function
// - output drives M(R(X)) then increments R(X)
// - io command lines low outside io
// - input writes memory and D, R(X) kept
// - command lines equal low N bits
// - N3 sets direction on read strobe
// - reset output low during power-up
// - only long branch/skip/nop take three cycles
// - taken long branch loads high then low
// - untaken long branch steps past two bytes
// - short branch replaces only low byte
// - short conditions D DF Q flags; skip byte
// - short skip two cycles, skips one byte
// - true long skip adds two, else continue
// - flags sampled at execute cycle start
// - inverted second timing pulse driven out
// - idle holds in idle state until dma request granted
package cbc_pkg;
	localparam int CBC_TCOUNTS = 8;
	localparam logic [2:0] CBC_T_PULSE_A = 3'h1;
	localparam logic [2:0] CBC_T_PULSE_B = 3'h6;
	localparam logic [2:0] CBC_T_WIN_LO = 3'h4;
	localparam logic [2:0] CBC_T_WIN_HI = 3'h7;
	localparam logic [3:0] CBC_I_IO = 4'h6;
	localparam logic [3:0] CBC_I_SHORT = 4'h3;
	localparam logic [3:0] CBC_I_LONG = 4'hc;
	localparam logic [3:0] CBC_I_SEX = 4'he;
	localparam logic [7:0] CBC_OP_IDLE = 8'h00;
	localparam logic [7:0] CBC_OP_NOP = 8'hc4;
	localparam int CBC_PWRUP_NS = 1000;
	localparam int CBC_CLK_NS = 10;
	localparam int CBC_PWRUP_CYC = (CBC_PWRUP_NS + CBC_CLK_NS - 1) / CBC_CLK_NS;
	typedef enum logic [2:0] {
		CBC_ST_FETCH = 3'b000,
		CBC_ST_EXEC = 3'b001,
		CBC_ST_EXEC2 = 3'b010,
		CBC_ST_DMA = 3'b011,
		CBC_ST_IDLE = 3'b100
	} cbc_state_t;
endpackage

/* cbc_core.sv */
// board processor core: io transfer, branch and skip sequencing
`timescale 1ns/100ps
module cbc_core
	import cbc_pkg::*;
#(
	parameter int PWRUP_CYC = CBC_PWRUP_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	output logic [15:0] mem_addr,
	input wire logic [7:0] mem_rdata,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	output logic memory_read_strobe,
	input wire logic [7:0] data_bus_in,
	output logic [7:0] data_bus_out,
	output logic data_bus_oe,
	output logic [2:0] io_command_lines,
	output logic io_out_valid,
	input wire logic io_out_ready,
	input wire logic [3:0] external_flag_inputs,
	input wire logic channel_in_request,
	input wire logic channel_out_request,
	output logic dma_grant_indication,
	output logic processor_output_flag,
	output logic second_timing_pulse,
	output logic inverted_second_pulse,
	output logic board_reset_n,
	input wire logic carry_flag,
	input wire logic interrupt_enable_flag,
	input wire logic [3:0] x_select,
	output logic [7:0] d_value,
	output logic [15:0] pc_value
);
	//----------------------------------------
	// state
	//----------------------------------------
	cbc_state_t st_ff, nxt_st;
	logic [2:0] tc_ff;
	logic [7:0] op_ff, nxt_op;
	logic [15:0] pc_ff, nxt_pc;
	logic [15:0] rx_ff, nxt_rx;
	logic [7:0] d_ff, nxt_d;
	logic [7:0] hi_ff, nxt_hi;
	logic q_ff;
	logic cond_ff, nxt_cond;
	logic [3:0] ef_s1_ff, ef_s2_ff, ef_ff;
	logic [7:0] bin_s1_ff, bin_s2_ff;
	logic [1:0] chin_s_ff, chout_s_ff;
	logic [15:0] pwr_cnt_ff;
	logic [7:0] buf0_ff, buf1_ff;
	logic [1:0] bcnt_ff;
	wire cyc_end = (tc_ff == 3'(CBC_TCOUNTS - 1));
	wire [3:0] op_i = op_ff[7:4];
	wire [3:0] op_n = op_ff[3:0];
	wire is_io = (st_ff == CBC_ST_EXEC) && (op_i == CBC_I_IO) && (op_n[2:0] != 3'h0);
	wire io_in = is_io && op_n[3];
	wire io_out = is_io && !op_n[3];
	wire in_win = (tc_ff >= CBC_T_WIN_LO) && (tc_ff <= CBC_T_WIN_HI);
	wire dma_req = !chin_s_ff[1] || !chout_s_ff[1];
	wire buf_full = (bcnt_ff == 2'h2);
	wire out_stall = io_out && cyc_end && buf_full;
	wire step = cyc_end && !out_stall;
	//----------------------------------------
	// condition decode
	//----------------------------------------
	function automatic logic cond_f(input logic [7:0] op, input logic [7:0] d,
		input logic df, input logic q, input logic ie, input logic [3:0] ef);
		logic c;
		c = 1'b0;
		case (op[2:0])
			3'h0: c = 1'b1;
			3'h1: c = q;
			3'h2: c = (d == 8'h00);
			3'h3: c = df;
			3'h4: c = ef[0];
			3'h5: c = ef[1];
			3'h6: c = ef[2];
			3'h7: c = ef[3];
			default: c = 1'b0;
		endcase
		if (op[7:4] == CBC_I_LONG) begin
			if (op[2]) begin
				case (op[1:0])
					2'h0: c = (op[3]) ? ie : 1'b1;
					2'h1: c = !q;
					2'h2: c = (d != 8'h00);
					2'h3: c = !df;
					default: c = 1'b0;
				endcase
				if (op[3] && op[1:0] != 2'h0) begin
					c = !c;
				end
				if (op == CBC_OP_NOP) begin
					c = 1'b0;
				end
			end else if (op[2:0] == 3'h0) begin
				c = 1'b1;
			end
		end
		if (op[3] && !(op[7:4] == CBC_I_LONG && op[2])) begin
			c = !c;
		end
		return c;
	endfunction
	wire cond_now = cond_f(op_ff, d_ff, carry_flag, q_ff, interrupt_enable_flag, ef_ff);
	//----------------------------------------
	// sequencing
	//----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_op = op_ff;
		nxt_pc = pc_ff;
		nxt_rx = rx_ff;
		nxt_d = d_ff;
		nxt_hi = hi_ff;
		nxt_cond = cond_ff;
		if (step) begin
			case (st_ff)
				CBC_ST_FETCH: begin
					nxt_op = mem_rdata;
					nxt_pc = pc_ff + 16'h0001;
					nxt_st = (mem_rdata == CBC_OP_IDLE) ? CBC_ST_IDLE : CBC_ST_EXEC;
				end
				CBC_ST_IDLE: begin
					nxt_st = dma_req ? CBC_ST_DMA : CBC_ST_IDLE;
				end
				CBC_ST_DMA: begin
					nxt_st = dma_req ? CBC_ST_DMA : CBC_ST_FETCH;
				end
				CBC_ST_EXEC: begin
					nxt_st = CBC_ST_FETCH;
					nxt_cond = cond_now;
					if (op_i == CBC_I_SHORT) begin
						nxt_pc = cond_now ? {pc_ff[15:8], mem_rdata} : pc_ff + 16'h0001;
					end else if (op_i == CBC_I_LONG && op_n != 4'h8 && op_n[2]) begin
						nxt_st = CBC_ST_EXEC2;
						nxt_pc = cond_now ? pc_ff + 16'h0001 : pc_ff;
					end else if (op_i == CBC_I_LONG) begin
						nxt_st = CBC_ST_EXEC2;
						nxt_hi = mem_rdata;
						nxt_pc = pc_ff + 16'h0001;
						nxt_cond = (op_n == 4'h8) ? 1'b0 : cond_now;
					end else if (io_out) begin
						nxt_rx = rx_ff + 16'h0001;
					end else if (io_in) begin
						nxt_d = bin_s2_ff;
					end
				end
				CBC_ST_EXEC2: begin
					nxt_st = CBC_ST_FETCH;
					if (op_n[2] && op_n != 4'h8) begin
						nxt_pc = cond_ff ? pc_ff + 16'h0001 : pc_ff;
					end else begin
						nxt_pc = cond_ff ? {hi_ff, mem_rdata} : pc_ff + 16'h0001;
					end
				end
				default: nxt_st = CBC_ST_FETCH;
			endcase
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n || !board_reset_n) begin
			st_ff <= CBC_ST_FETCH;
			tc_ff <= 3'h0;
			op_ff <= 8'h00;
			pc_ff <= 16'h0000;
			d_ff <= 8'h00;
			hi_ff <= 8'h00;
			cond_ff <= 1'b0;
		end else begin
			tc_ff <= out_stall ? tc_ff : tc_ff + 3'h1;
			st_ff <= nxt_st;
			op_ff <= nxt_op;
			pc_ff <= nxt_pc;
			d_ff <= nxt_d;
			hi_ff <= nxt_hi;
			cond_ff <= nxt_cond;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rx_ff <= 16'h0000;
			q_ff <= 1'b0;
			pwr_cnt_ff <= 16'h0000;
			board_reset_n <= 1'b0;
		end else begin
			rx_ff <= (st_ff == CBC_ST_EXEC && op_i == CBC_I_SEX) ? 16'h0000 : nxt_rx;
			q_ff <= (op_ff == 8'h7b) ? 1'b1 : (op_ff == 8'h7a) ? 1'b0 : q_ff;
			if (pwr_cnt_ff != 16'(PWRUP_CYC)) begin
				pwr_cnt_ff <= pwr_cnt_ff + 16'h0001;
			end
			board_reset_n <= (pwr_cnt_ff == 16'(PWRUP_CYC));
		end
	end
	//----------------------------------------
	// input synchronisers and flag sample
	//----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ef_s1_ff <= 4'h0;
			ef_s2_ff <= 4'h0;
			ef_ff <= 4'h0;
			bin_s1_ff <= 8'h00;
			bin_s2_ff <= 8'h00;
			chin_s_ff <= 2'h3;
			chout_s_ff <= 2'h3;
		end else begin
			ef_s1_ff <= external_flag_inputs;
			ef_s2_ff <= ef_s1_ff;
			bin_s1_ff <= data_bus_in;
			bin_s2_ff <= bin_s1_ff;
			chin_s_ff <= {chin_s_ff[0], channel_in_request};
			chout_s_ff <= {chout_s_ff[0], channel_out_request};
			if (step && nxt_st == CBC_ST_EXEC) begin
				ef_ff <= ef_s2_ff;
			end
		end
	end
	//----------------------------------------
	// output byte buffer
	//----------------------------------------
	// push on the step edge, so a byte held off by a full buffer is not lost
	wire buf_push = io_out && cyc_end && !buf_full;
	wire buf_pop = io_out_valid && io_out_ready;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			bcnt_ff <= 2'h0;
			buf0_ff <= 8'h00;
			buf1_ff <= 8'h00;
		end else begin
			if (buf_pop) begin
				buf0_ff <= buf1_ff;
			end
			if (buf_push) begin
				if (bcnt_ff == 2'h0 || (bcnt_ff == 2'h1 && buf_pop)) begin
					buf0_ff <= mem_rdata;
				end else begin
					buf1_ff <= mem_rdata;
				end
			end
			bcnt_ff <= bcnt_ff + 2'(buf_push) - 2'(buf_pop);
		end
	end
	//----------------------------------------
	// outputs
	//----------------------------------------
	assign io_out_valid = (bcnt_ff != 2'h0);
	assign data_bus_out = buf0_ff;
	assign data_bus_oe = io_out_valid && !io_in;
	assign io_command_lines = is_io ? op_n[2:0] : 3'h0;
	assign memory_read_strobe = is_io && op_n[3];
	assign mem_addr = (is_io) ? rx_ff : pc_ff;
	assign mem_we = io_in && in_win;
	assign mem_wdata = bin_s2_ff;
	assign dma_grant_indication = (st_ff == CBC_ST_DMA);
	assign second_timing_pulse = (tc_ff == CBC_T_PULSE_B);
	assign inverted_second_pulse = !second_timing_pulse;
	assign processor_output_flag = q_ff;
	assign d_value = d_ff;
	assign pc_value = pc_ff;
endmodule

/* cbc_monitor.sv */
// checker on the core ports
`timescale 1ns/100ps
module cbc_monitor #(
	parameter int PWRUP_CYC = 4
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic mem_we,
	input wire logic memory_read_strobe,
	input wire logic [7:0] data_bus_out,
	input wire logic data_bus_oe,
	input wire logic [2:0] io_command_lines,
	input wire logic io_out_valid,
	input wire logic io_out_ready,
	input wire logic dma_grant_indication,
	input wire logic second_timing_pulse,
	input wire logic inverted_second_pulse,
	input wire logic board_reset_n
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence s_we_on;
		mem_we [*4];
	endsequence
	sequence s_rst_low;
		(!board_reset_n) [*4];
	endsequence
	a_inv_pulse: assert property (inverted_second_pulse == !second_timing_pulse)
		else $error("inverted pulse wrong");
	a_we_window: assert property
		($rose(mem_we) && !dma_grant_indication |-> s_we_on ##1 !mem_we)
		else $error("write window not four counts");
	a_we_dir: assert property
		(mem_we && !dma_grant_indication |-> memory_read_strobe)
		else $error("write without read strobe");
	a_in_undriven: assert property (memory_read_strobe |-> !data_bus_oe)
		else $error("bus driven during input");
	a_in_cmd: assert property
		(memory_read_strobe && !dma_grant_indication |-> io_command_lines != 3'h0)
		else $error("command lines low in input");
	a_dma_cmd: assert property (dma_grant_indication |-> io_command_lines == 3'h0)
		else $error("command lines high in dma");
	a_out_hold: assert property
		(io_out_valid && !io_out_ready |=> io_out_valid && $stable(data_bus_out))
		else $error("output byte lost in stall");
	a_pwr_low: assert property ($rose(rst_n) |-> s_rst_low ##[0:4] board_reset_n)
		else $error("reset output timing wrong");
endmodule
bind cbc_core cbc_monitor #(.PWRUP_CYC(PWRUP_CYC)) mon_u (
	.clk_sys(clk_sys), .rst_n(rst_n), .mem_we(mem_we),
	.memory_read_strobe(memory_read_strobe), .data_bus_out(data_bus_out),
	.data_bus_oe(data_bus_oe), .io_command_lines(io_command_lines),
	.io_out_valid(io_out_valid), .io_out_ready(io_out_ready),
	.dma_grant_indication(dma_grant_indication), .second_timing_pulse(second_timing_pulse),
	.inverted_second_pulse(inverted_second_pulse), .board_reset_n(board_reset_n)
);

/* cbc_io_model.sv */
// io controller model: takes output bytes, supplies input bytes
`timescale 1ns/100ps
module cbc_io_model (
	input wire logic clk_sys,
	input wire logic [7:0] data_bus_out,
	input wire logic io_out_valid,
	output logic io_out_ready,
	input wire logic memory_read_strobe,
	input wire logic [2:0] io_command_lines,
	input wire logic [7:0] in_base,
	output logic [7:0] data_bus_in,
	output logic cap_stb,
	output logic [7:0] cap_byte
);
	logic [5:0] st_ff = 6'h0;
	initial data_bus_in = 8'h5a;
	assign io_out_ready = st_ff[5];
	assign cap_stb = io_out_valid & io_out_ready;
	assign cap_byte = data_bus_out;
	always @(posedge clk_sys) begin
		st_ff <= st_ff + 6'h1;
		if (memory_read_strobe)
			data_bus_in <= in_base + {5'h0, io_command_lines};
		else
			data_bus_in <= ~data_bus_in;
	end
endmodule

/* tb.sv */
// self-checking bench: program memory, io model, branch programs
`timescale 1ns/100ps
module tb;
	import cbc_pkg::*;
	logic clk_sys = 0, rst_n = 0, chin = 1, df = 0, ie = 0;
	logic [3:0] ef = 0;
	logic [7:0] in_base = 0, mem_wdata, data_bus_out, data_bus_in, d_value, cap_byte;
	logic mem_we, memory_read_strobe, data_bus_oe, io_out_valid, io_out_ready, cap_stb;
	logic dma_grant_indication, second_timing_pulse, inverted_second_pulse, board_reset_n, q_out;
	logic [2:0] io_command_lines, cmd_ff = 0;
	logic [15:0] mem_addr, pc_value, rnd = 16'hd91c;
	logic [7:0] mem [0:255];
	logic [10:0] eq[$], gq[$];
	logic [7:0] bq[$];
	int fails = 0, tests_run = 0;
	cbc_core #(.PWRUP_CYC(4)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .mem_addr(mem_addr),
		.mem_rdata(mem[mem_addr[7:0]]), .mem_wdata(mem_wdata), .mem_we(mem_we),
		.memory_read_strobe(memory_read_strobe), .data_bus_in(data_bus_in),
		.data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
		.io_command_lines(io_command_lines), .io_out_valid(io_out_valid),
		.io_out_ready(io_out_ready), .external_flag_inputs(ef), .channel_in_request(chin),
		.channel_out_request(1'b1), .dma_grant_indication(dma_grant_indication),
		.processor_output_flag(q_out), .second_timing_pulse(second_timing_pulse),
		.inverted_second_pulse(inverted_second_pulse), .board_reset_n(board_reset_n),
		.carry_flag(df), .interrupt_enable_flag(ie), .x_select(4'h0), .d_value(d_value),
		.pc_value(pc_value));
	cbc_io_model io_u (.clk_sys(clk_sys), .data_bus_out(data_bus_out),
		.io_out_valid(io_out_valid), .io_out_ready(io_out_ready),
		.memory_read_strobe(memory_read_strobe), .io_command_lines(io_command_lines),
		.in_base(in_base), .data_bus_in(data_bus_in), .cap_stb(cap_stb), .cap_byte(cap_byte));
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (cap_stb)
			bq.push_back(cap_byte);
		if (io_command_lines != 3'h0 && cmd_ff == 3'h0 && !memory_read_strobe)
			gq.push_back({io_command_lines, 8'h0});
		cmd_ff <= io_command_lines;
		if (mem_we)
			mem[mem_addr[7:0]] <= mem_wdata;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic taken(input logic [7:0] op);
		logic [7:0] b;
		b = {ef, df, 1'b1, 1'b0, 1'b1};
		if (op[7:4] == 4'h3)
			return b[op[2:0]] ^ op[3];
		if (!op[2])
			return b[op[1:0]] ^ op[3];
		if (op[1:0] == 2'h0)
			return op[3] & ie;
		return b[op[1:0]] ^ !op[3];
	endfunction
	task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic end_sim();
		$display("fails %0d tests_run %0d", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wt(input logic sel, input logic [15:0] v);
		int k;
		for (k = 0; k < 20000 && (sel ? {15'h0, dma_grant_indication} : pc_value) !== v; k++)
			@(posedge clk_sys);
		if (k == 20000) begin
			fails++;
			end_sim();
		end
	endtask
	initial begin
		logic [7:0] a, op, n, t, m1;
		for (int r = 0; r < 3; r++) begin
			@(posedge clk_sys);
			rst_n <= 0;
			rnd = lfsr(rnd);
			{in_base, ie, df, ef} <= rnd[13:0];
			repeat (3) @(posedge clk_sys);
			a = 0;
			eq.delete();
			gq.delete();
			bq.delete();
			for (int i = 0; i < 256; i++)
				mem[i] = 8'h00;
			for (int i = 0; i < 32; i++) begin
				op = (i < 16) ? 8'h30 + i[7:0] : 8'hb0 + i[7:0];
				n = (op[7:4] == 4'h3) ? 8'h1 : (op[2] ? 8'h0 : 8'h2);
				t = a + n + 8'h3;
				mem[a + 8'h1] = 8'h00;
				mem[a + n] = t;
				mem[a] = op;
				mem[t - 8'h2] = 8'h61;
				mem[t - 8'h1] = CBC_OP_NOP;
				mem[t] = 8'h62;
				// out bytes come from R(X), which walks up from zero
				if (!taken(op))
					eq.push_back({3'h1, mem[eq.size()]});
				eq.push_back({3'h2, mem[eq.size()]});
				a = t + 8'h1;
			end
			{mem[a], mem[a + 8'h1], mem[a + 8'h2]} = 24'he1696a;
			m1 = mem[1];
			rst_n <= 1;
			wt(0, {8'h0, a + 8'h4});
			check("count", 16'(gq.size()), 16'(eq.size()));
			check("bytes", 16'(bq.size()), 16'(eq.size()));
			for (int i = 0; i < eq.size(); i++)
				check("out", {5'h0, gq[i][10:8], bq[i]}, {5'h0, eq[i]});
			check("mem0", {8'h0, mem[0]}, {8'h0, in_base + 8'h2});
			check("mem1", {8'h0, mem[1]}, {8'h0, m1});
			check("d", {8'h0, d_value}, {8'h0, in_base + 8'h2});
			check("q", {15'h0, q_out}, 16'h0);
			chin <= 0;
			wt(1, 16'h1);
			chin <= 1;
			wt(1, 16'h0);
		end
		end_sim();
	end
endmodule
